//--- sim/flash_dev_model.sv
// Purpose: behavioural flash status model for the poller bench
// Assumes: bench loads op (0 program, 1 erase, 2 stuck, 3 suspended sector), word and busy read count
// Notes: released busy pin shows the pull-up level
`timescale 1ns/100ps
module flash_dev_model
  import flash_poll_pkg::*;
(
  input wire logic clk_i,
  input wire logic load_i,
  input wire logic [1:0] op_i,
  input wire logic [15:0] word_i,
  input wire logic [7:0] count_i,
  input wire strobe_t strobe_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic busy_n_o,
  output logic [15:0] last_wr_o
);
  logic [7:0] left = 8'h00;
  logic [1:0] op = 2'h0;
  logic tog = 1'b0;
  strobe_t prev = '1;
  logic [15:0] st;
  logic [15:0] word_out;
  logic [15:0] sus;
  // status word while busy; erase shows timer bit set at once
  assign st = (op == 2'h1) ? {8'h00, 1'b0, tog, 1'b0, 1'b0, 1'b1, tog, 2'b00}
            : {word_i[15:8], ~word_i[7], tog, op[1], word_i[4], 2'b00, word_i[1:0]};
  // erase-suspended sector: top line reads 1, toggle two toggles, toggle one stands
  assign sus = {8'h00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, tog, 2'b00};
  assign word_out = (op == 2'h3) ? sus : (left != 8'h00) ? st : ((op == 2'h1) ? 16'hffff : word_i);
  // deselected bus shows the inverse so a stale sample is caught
  assign dq_o = (!strobe_i.ce_n && !strobe_i.oe_n) ? word_out : ~word_out;
  assign busy_n_o = (left == 8'h00) || (op == 2'h3);
  // reads are counted as the output strobe ends; a stuck program ends only on the reset command
  always @(posedge clk_i) begin
    prev <= strobe_i;
    if (load_i) begin
      op <= op_i;
      left <= count_i;
      tog <= 1'b0;
    end else if (strobe_i.oe_n && !prev.oe_n && left != 8'h00) begin
      tog <= ~tog;
      if (!op[1]) left <= left - 8'h01;
    end else if (strobe_i.we_n && !prev.we_n) begin
      last_wr_o <= dq_i;
      if (dq_i == 16'h00f0) left <= 8'h00;
    end
  end
endmodule

//--- sim/flash_poller_bench.sv
// Purpose: self-checking bench for the flash status poller
// Assumes: device model on the flash pins, classic wishbone master tasks
// Notes: rows cover program and erase in both poll modes
`timescale 1ns/100ps
`include "flash_poll_regs.svh"
module flash_poller_bench;
  import flash_poll_pkg::*;
  typedef struct packed {
    logic [1:0] op;
    logic [7:0] cnt;
    logic mode;
    logic [15:0] word;
    logic [15:0] last;
    logic fail;
  } row_t;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, load = 1'b0;
  logic [7:0] adr = 8'h00, cnt = 8'h00;
  logic [31:0] wdat = 32'h0, dat_o, rd;
  logic ack, dq_oe, busy_n;
  logic [1:0] op = 2'h0;
  logic [15:0] word = 16'h0, host_dq, dev_dq, last_wr;
  logic [20:0] faddr;
  strobe_t strobe;
  int num_errors = 0, tests_run = 0;
  `define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    $display("Error %s expected %h seen %h", nm, e, g); num_errors++; end end
  always #20 clk = ~clk;
  flash_poller uut (.core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .flash_addr_o(faddr), .flash_strobe_o(strobe), .flash_dq_o(host_dq), .flash_dq_oe_o(dq_oe),
    .flash_dq_i(dq_oe ? host_dq : dev_dq), .busy_out_n_i(busy_n));
  flash_dev_model dev (.clk_i(clk), .load_i(load), .op_i(op), .word_i(word), .count_i(cnt),
    .strobe_i(strobe), .dq_i(host_dq), .dq_o(dev_dq), .busy_n_o(busy_n), .last_wr_o(last_wr));
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      test_done();
    end
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  // poll the status register until the run ends, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    do begin wb(1'b0, `REG_STAT, 32'h0); n++; end while (rd[`STAT_BUSY] !== 1'b0 && n < 200);
    if (n >= 200) begin
      num_errors++;
      test_done();
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // last is the word of the read after completion; suspended reads end on the second status word
  localparam row_t rows [7] = '{
    '{2'h0, 8'h03, 1'b0, 16'h12a5, 16'h12a5, 1'b0},
    '{2'h0, 8'h01, 1'b0, 16'h0f0f, 16'h0f0f, 1'b0},
    '{2'h1, 8'h05, 1'b0, 16'h0000, 16'hffff, 1'b0},
    '{2'h0, 8'h04, 1'b1, 16'h55aa, 16'h55aa, 1'b0},
    '{2'h1, 8'h04, 1'b1, 16'h0000, 16'hffff, 1'b0},
    '{2'h3, 8'h02, 1'b1, 16'h0000, 16'h0084, 1'b0},
    '{2'h2, 8'h02, 1'b0, 16'h3c81, 16'h0000, 1'b1}};
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    wb(1'b0, `REG_STAT, 32'h0);
    `CHK("stat after reset", 32'h8, rd)
    wb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    $display("reset test done");
    // ordinary runs, one per row
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      op <= rows[i].op; cnt <= rows[i].cnt; word <= rows[i].word; load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      wb(1'b1, `REG_ADDR, 32'h1a000 + i);
      wb(1'b1, `REG_DATA, {16'h0, rows[i].op[0] ? 16'hffff : rows[i].word});
      wb(1'b1, `REG_CTRL, {30'h0, rows[i].mode, 1'b1});
      wait_idle();
      `CHK("fail flag", rows[i].fail, rd[`STAT_FAIL])
      `CHK("done flag", !rows[i].fail, rd[`STAT_DONE])
      `CHK("poll address", 21'h1a000 + i, faddr)
      if (!rows[i].fail) begin
        wb(1'b0, `REG_RDAT, 32'h0);
        `CHK("last word", {16'h0, rows[i].last}, rd)
      end
      $display("row %0d done", i);
    end
    // reset command after a stuck program returns the device to reads
    wb(1'b1, `REG_CTRL, 32'h5);
    wait_idle();
    `CHK("reset command word", 16'h00f0, last_wr)
    repeat (4) @(posedge clk);
    wb(1'b0, `REG_STAT, 32'h0);
    `CHK("busy pin released", 1'b1, rd[`STAT_PIN])
    $display("reset command test done");
    // reset in mid-run: strobes and drive return to idle at once, pin still busy
    @(posedge clk);
    op <= 2'h2; cnt <= 8'h02; word <= 16'h3c81; load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    wb(1'b1, `REG_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    `CHK("strobe during run", 3'b001, strobe)
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("strobe after reset", 3'b111, strobe)
    `CHK("drive after reset", 1'b0, dq_oe)
    wb(1'b0, `REG_STAT, 32'h0);
    `CHK("stat after mid reset", 32'h0, rd)
    wb(1'b1, `REG_CTRL, 32'h5);
    wait_idle();
    `CHK("reset command after reset", 16'h00f0, last_wr)
    $display("mid-run reset test done");
    test_done();
  end
endmodule

//--- src/flash_poll_pkg.sv
// Purpose: types for the host-side flash status poller
// Assumes: nothing beyond the constants header
// Notes: bus strobes travel as one struct
package flash_poll_pkg;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } strobe_t;
  typedef enum logic {
    mode_toggle,
    mode_data
  } poll_mode_t;
endpackage

//--- src/flash_poll_regs.svh
// Purpose: constants for the host-side flash status poller
// Assumes: 25 MHz core clock, classic wishbone register port
// Notes: offsets are byte addresses of 32-bit words
// Notes on behaviour
// - host polls at an address inside the target sector, never a protected one
// - top bit may flip early; host takes full word from a later read
// - after an error the host writes the reset command; the poller only sets fail, software starts the write with CTRL_CMD
// - error bit may be stale; host rechecks toggle bit one
// - host reads full word twice and compares the toggle bits
// - toggling with error bit high: recheck, then reset if still toggling; the poller sets fail and stops, reset waits for a CTRL_CMD start
`ifndef FLASH_POLL_REGS_SVH
`define FLASH_POLL_REGS_SVH
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_STAT 8'h0c
`define REG_RDAT 8'h10
`define CTRL_START 0
`define CTRL_MODE 1
`define CTRL_CMD 2
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_FAIL 2
`define STAT_PIN 3
`define BIT_TOP 7
`define BIT_TOG1 6
`define BIT_ERR 5
`define BIT_TIMER 3
`define BIT_TOG2 2
`define RESET_CMD 16'h00f0
`define ACCESS_NS 120
`define ACCESS_CYC ((`ACCESS_NS * 25 + 999) / 1000)
`endif

//--- src/flash_poller.sv
// Purpose: host controller that polls a parallel nor flash for program/erase completion
// Assumes: wishbone classic slave, flash reached only through its pins
// Notes: one poll run per start; result in the status register
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "flash_poll_regs.svh"
module flash_poller
  import flash_poll_pkg::*;
#(
  parameter int AW = 21,
  parameter int DW = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [AW-1:0] flash_addr_o,
  output strobe_t flash_strobe_o,
  output logic [DW-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [DW-1:0] flash_dq_i,
  input wire logic busy_out_n_i
);
  typedef enum {
    st_idle,
    st_read,
    st_check,
    st_write,
    st_end
  } state_t;

  state_t state;
  logic [AW-1:0] addr;
  logic [DW-1:0] expect_data;
  logic confirm;
  poll_mode_t mode;
  logic busy, done, fail;
  logic [DW-1:0] last_rd, rdat;
  logic have_prev, err_seen;
  logic [7:0] cnt;
  logic [DW-1:0] dq_s1, dq_s2;
  logic busy_s1, busy_s2;

  // pins come from outside the clock domain: two flops before any use
  always_ff @(posedge core_clk_i) begin
    dq_s1 <= flash_dq_i;
    dq_s2 <= dq_s1;
    busy_s1 <= busy_out_n_i;
    busy_s2 <= busy_s1;
  end

  // bus decode; answer one cycle after the request, ack drops next cycle
  wire sel = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = sel && wb_we_i;
  wire start_wr = wr && wb_adr_i == `REG_CTRL && wb_sel_i[0] && wb_dat_i[`CTRL_START] && !busy;
  wire [31:0] stat_word = {28'h0, busy_s2, fail, done, busy};
  wire [31:0] rd_mux = wb_adr_i == `REG_CTRL ? {31'h0, mode} :
                       wb_adr_i == `REG_ADDR ? 32'(addr) :
                       wb_adr_i == `REG_DATA ? 32'(expect_data) :
                       wb_adr_i == `REG_STAT ? stat_word :
                       wb_adr_i == `REG_RDAT ? 32'(rdat) : 32'h0;
  wire timer_done = cnt == 8'(`ACCESS_CYC);
  // toggle compare: tog1 and tog2 must both match; error bit seen while toggling forces one recheck
  wire tog_same = dq_s2[`BIT_TOG1] == last_rd[`BIT_TOG1] && dq_s2[`BIT_TOG2] == last_rd[`BIT_TOG2];
  // data polling: top line equal to expected means done, but the word is taken on a later read
  wire top_match = dq_s2[`BIT_TOP] == expect_data[`BIT_TOP];

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= sel;
      wb_dat_o <= sel && !wb_we_i ? rd_mux : 32'h0;
    end
  end

  // configuration registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      addr <= '0;
      expect_data <= '0;
      mode <= mode_toggle;
    end else if (wr && !busy) begin
      if (wb_adr_i == `REG_ADDR) addr <= AW'(wb_dat_i);
      if (wb_adr_i == `REG_DATA) expect_data <= DW'(wb_dat_i);
      if (wb_adr_i == `REG_CTRL) mode <= poll_mode_t'(wb_dat_i[`CTRL_MODE]);
    end
  end

  // poll engine: a read holds its strobes for ACCESS_CYC+3 cycles, the reset command write for ACCESS_CYC+1
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= st_idle;
      busy <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      cnt <= 8'h0;
      have_prev <= 1'b0;
      err_seen <= 1'b0;
      confirm <= 1'b0;
      last_rd <= '0;
      rdat <= '0;
      flash_strobe_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      flash_addr_o <= '0;
      flash_dq_o <= '0;
      flash_dq_oe_o <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          if (start_wr) begin
            busy <= 1'b1;
            done <= 1'b0;
            fail <= 1'b0;
            have_prev <= 1'b0;
            err_seen <= 1'b0;
            confirm <= 1'b0;
            flash_addr_o <= addr;
            cnt <= 8'h0;
            if (wb_dat_i[`CTRL_CMD]) begin
              // software asked for the reset command after a failure
              flash_dq_o <= DW'(`RESET_CMD);
              flash_dq_oe_o <= 1'b1;
              flash_strobe_o <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
              state <= st_write;
            end else begin
              flash_strobe_o <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
              state <= st_read;
            end
          end
        end
        st_read: begin
          cnt <= cnt + 8'h1;
          // wait access time plus two synchroniser stages before sampling
          if (cnt == 8'(`ACCESS_CYC + 2)) begin
            flash_strobe_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            cnt <= 8'h0;
            state <= st_check;
          end
        end
        st_check: begin
          last_rd <= dq_s2;
          have_prev <= 1'b1;
          rdat <= dq_s2;
          state <= st_read;
          flash_strobe_o <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
          if (mode == mode_data) begin
            if (confirm) begin
              // word taken from the read after the match, since the low lines may lag the top line
              done <= 1'b1;
              state <= st_end;
              flash_strobe_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            end else if (top_match) begin
              confirm <= 1'b1;
            end else if (dq_s2[`BIT_ERR]) begin
              err_seen <= 1'b1;
              if (err_seen) begin
                fail <= 1'b1;
                state <= st_end;
                flash_strobe_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
              end
            end
          end else if (have_prev) begin
            if (tog_same) begin
              done <= 1'b1;
              state <= st_end;
              flash_strobe_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            end else if (dq_s2[`BIT_ERR] || err_seen) begin
              // recheck once more after the error bit shows; still toggling means failure
              if (err_seen) begin
                fail <= 1'b1;
                state <= st_end;
                flash_strobe_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
              end
              err_seen <= 1'b1;
            end
          end
        end
        st_write: begin
          cnt <= cnt + 8'h1;
          if (timer_done) begin
            flash_strobe_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            flash_dq_oe_o <= 1'b0;
            done <= 1'b1;
            state <= st_end;
          end
        end
        st_end: begin
          busy <= 1'b0;
          state <= st_idle;
        end
        default: state <= st_idle;
      endcase
    end
  end

  // strobes never overlap read and write
  strobe_excl_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(!flash_strobe_o.oe_n && !flash_strobe_o.we_n)) else $error("oe and we low together");
  // toggle mode finishes once two toggle samples are equal
  tog_done_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state == st_check && mode == mode_toggle && have_prev && tog_same) |=> done)
    else $error("toggle match did not finish");
  // failure needs the error bit seen on an earlier read
  fail_cause_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(fail) |-> $past(err_seen)) else $error("fail without recheck");
  // reset command drives the bus only while we is low
  drive_we_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    flash_dq_oe_o |-> !flash_strobe_o.we_n) else $error("data driven outside write");
  // data-mode completion needs a prior read
  data_later_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state == st_check && mode == mode_data && !have_prev) |=> !done) else $error("done on first read");
  // a top-line match starts one more read instead of finishing at once
  match_reread_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (state == st_check && mode == mode_data && !confirm && top_match) |=> (!done && state == st_read))
    else $error("match did not start a confirming read");
  // every run returns to idle with busy clear
  end_idle_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state == st_end |=> (state == st_idle && !busy)) else $error("end did not release");
endmodule
